//--- rtl/dcm_pkg.sv
// Purpose: Shared constants and types for the command link of the DRAM calibration block.
// Assumes: One 25 MHz clock drives both ends; times below are in picoseconds.
// Notes:   Cycle counts are derived from times and rounded up to whole cycles.
package dcm_pkg;

  localparam int unsigned CLK_PERIOD_PS = 40000;

  // Timing limits in picoseconds, converted by rounding up.
  localparam int unsigned T_RP_PS    = 15000;
  localparam int unsigned T_MRD_PS   = 160000;
  localparam int unsigned T_MOD_PS   = 480000;
  localparam int unsigned T_MPRR_PS  = 40000;
  localparam int unsigned T_RCD_PS   = 15000;
  localparam int unsigned T_RC_PS    = 50000;
  localparam int unsigned T_RRD_PS   = 10000;
  localparam int unsigned T_FAW_PS   = 40000;
  localparam int unsigned T_CCD_PS   = 160000;
  localparam int unsigned T_ZQOPER_PS = 10240000;
  localparam int unsigned T_ZQCS_PS   = 2560000;

  function automatic logic [15:0] dcm_cyc(input int unsigned ps);
    int unsigned c;
    c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    if (c < 1) begin
      c = 1;
    end
    return c[15:0];
  endfunction : dcm_cyc

  localparam logic [15:0] RP_CYC     = dcm_cyc(T_RP_PS);
  localparam logic [15:0] MRD_CYC    = dcm_cyc(T_MRD_PS);
  localparam logic [15:0] MOD_CYC    = dcm_cyc(T_MOD_PS);
  localparam logic [15:0] MPRR_CYC   = dcm_cyc(T_MPRR_PS);
  localparam logic [15:0] RCD_CYC    = dcm_cyc(T_RCD_PS);
  localparam logic [15:0] RC_CYC     = dcm_cyc(T_RC_PS);
  localparam logic [15:0] RRD_CYC    = dcm_cyc(T_RRD_PS);
  localparam logic [15:0] FAW_CYC    = dcm_cyc(T_FAW_PS);
  localparam logic [15:0] CCD_CYC    = dcm_cyc(T_CCD_PS);
  localparam logic [15:0] ZQOPER_CYC = dcm_cyc(T_ZQOPER_PS);
  localparam logic [15:0] ZQCS_CYC   = dcm_cyc(T_ZQCS_PS);

  // Latency defaults and address fields.
  localparam logic [3:0] AL_RST        = 4'h0;
  localparam logic [3:0] CL_RST        = 4'h5;
  localparam int unsigned PAT_BIT      = 2;
  localparam int unsigned BURST_SEL_BIT = 12;
  localparam int unsigned NIBBLE_BIT   = 2;
  localparam logic [7:0] CAL_PATTERN   = 8'haa;
  localparam logic [2:0] MR_THREE_SEL  = 3'h3;
  localparam logic [1:0] ACT_WINDOW_N  = 2'h3;

  // Command encodings carried on the link.
  typedef enum logic [3:0] {
    DCM_NOP  = 4'h0,
    DCM_ACT  = 4'h1,
    DCM_RD   = 4'h2,
    DCM_WR   = 4'h3,
    DCM_PREA = 4'h4,
    DCM_MRS  = 4'h5,
    DCM_ZQCL = 4'h6,
    DCM_ZQCS = 4'h7
  } dcm_cmd_t;

  // APB register offsets of the controller.
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_ADDR   = 8'h08;
  localparam logic [7:0] REG_RDATA  = 8'h0c;

endpackage : dcm_pkg

//--- rtl/dcm_link_if.sv
// Purpose: Command, address and data link between controller and DRAM model end.
// Assumes: Both ends on ref_clk; dq is driven by the DRAM end only.
// Notes:   The resolved data level is worked out here from the enable.
`timescale 1ns/1ns
interface dcm_link_if;
  import dcm_pkg::*;
  dcm_cmd_t    cmd;
  logic [2:0]  ba;
  logic [13:0] addr;
  logic        cke;
  logic        odt;
  logic [7:0]  dq_o;
  logic [7:0]  dq_oe;
  logic [7:0]  dq;
  logic        zq_path_on;

  assign dq = dq_o & dq_oe;

  modport ctrl (output cmd, ba, addr, cke, odt, input dq, zq_path_on);
  modport dram (input cmd, ba, addr, cke, odt, output dq_o, dq_oe, zq_path_on);
endinterface : dcm_link_if

//--- rtl/dcm_dram.sv
// Purpose: DRAM end: mode registers, pattern-register reads and impedance calibration.
// Assumes: Commands arrive one per cycle on the same clock as the controller.
// Notes:   The pattern burst is one bit per beat on every data line.
`timescale 1ns/1ns
module dcm_dram (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  input  wire logic clk_en,
  // Link
  dcm_link_if.dram  lnk,
  // User side
  output logic [13:0] mode_reg_q [4],
  output logic        pat_mode_q
);
  import dcm_pkg::*;

  logic [15:0] mod_cnt_q;
  logic [4:0]  rl_cnt_q;
  logic        rl_run_q;
  logic [2:0]  beat_q;
  logic        burst_q;
  logic        bc4_q;
  logic        upper_q;
  logic [15:0] zq_cnt_q;

  // Mode register load selected by bank address.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < 4; i++) begin
        mode_reg_q[i] <= 14'h0000;
      end
    end else if (clk_en && lnk.cmd == DCM_MRS && lnk.ba[2] == 1'b0) begin
      mode_reg_q[lnk.ba[1:0]] <= lnk.addr;
    end
  end

  // Pattern mode takes effect after the mode update delay (MOD_CYC, not MRD_CYC).
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mod_cnt_q  <= 16'h0000;
      pat_mode_q <= 1'b0;
    end else if (clk_en) begin
      if (lnk.cmd == DCM_MRS && lnk.ba == MR_THREE_SEL) begin
        mod_cnt_q <= MOD_CYC;
      end else if (mod_cnt_q != 16'h0000) begin
        mod_cnt_q <= mod_cnt_q - 16'h0001;
        if (mod_cnt_q == 16'h0001) begin
          pat_mode_q <= mode_reg_q[3][PAT_BIT];
        end
      end
    end
  end

  // Read latency then an eight- or four-beat pattern burst.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rl_cnt_q <= 5'h00;
      rl_run_q <= 1'b0;
      burst_q  <= 1'b0;
      beat_q   <= 3'h0;
      bc4_q    <= 1'b0;
      upper_q  <= 1'b0;
    end else if (clk_en) begin
      if (lnk.cmd == DCM_RD && pat_mode_q) begin
        rl_cnt_q <= 5'(mode_reg_q[1][6:3]) + 5'(mode_reg_q[0][7:4]);
        rl_run_q <= 1'b1;
        bc4_q    <= ~lnk.addr[BURST_SEL_BIT];
        upper_q  <= lnk.addr[NIBBLE_BIT];
      end else if (rl_run_q) begin
        if (rl_cnt_q <= 5'h01) begin
          rl_run_q <= 1'b0;
          burst_q  <= 1'b1;
          beat_q   <= {upper_q & bc4_q, 2'h0};
        end else begin
          rl_cnt_q <= rl_cnt_q - 5'h01;
        end
      end else if (burst_q) begin
        beat_q <= beat_q + 3'h1;
        if (beat_q == 3'h7 || (bc4_q && beat_q[1:0] == 2'h3)) begin
          burst_q <= 1'b0;
        end
      end
    end
  end

  always_comb begin
    lnk.dq_oe = burst_q ? 8'hff : 8'h00;
    lnk.dq_o  = CAL_PATTERN[beat_q] ? 8'hff : 8'h00;
  end

  // Calibration current path is on only while a calibration runs.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      zq_cnt_q <= 16'h0000;
    end else if (clk_en) begin
      if (lnk.cmd == DCM_ZQCL) begin
        zq_cnt_q <= ZQOPER_CYC;
      end else if (lnk.cmd == DCM_ZQCS) begin
        zq_cnt_q <= ZQCS_CYC;
      end else if (zq_cnt_q != 16'h0000) begin
        zq_cnt_q <= zq_cnt_q - 16'h0001;
      end
    end
  end

  assign lnk.zq_path_on = (zq_cnt_q != 16'h0000);

endmodule : dcm_dram

//--- rtl/dcm_ctrl.sv
// Purpose: Controller end: APB-driven command issue with timing guards and calibration.
// Assumes: Software writes one command at a time; timing is checked in hardware, except tMOD before PREA, ZQCL and ZQCS.
// Notes:   A command that would break a timing limit waits; it is never dropped.
`timescale 1ns/1ns
// How it works
// - Calibration: precharge, wait, set pattern mode.
// - DRAM serves reads from pattern register.
// - No writes while pattern mode selected.
// - Calibration read drives A1:0=00, A2=0, A12=1; the code passes A2 through from software.
// - Pattern arrives after AL plus CL.
// - Software repeats reads until capture optimal.
// - After tMPRR, clear pattern mode bit.
// - Regular commands wait tMRD and tMOD; PREA, ZQCL and ZQCS here wait only tMRD.
// - Bank address selects loaded mode register.
// - Mode set only with banks idle, tRP met.
// - Wait tMRD and tMOD after mode set; PREA, ZQCL and ZQCS here wait only tMRD.
// - Impedance calibration needs precharge and tRP.
// - Only calibration commands during calibration quiet.
// - DRAM turns calibration current off afterward.
// - Calibration after self-refresh exit is explicit.
// - Ranks never overlap calibration intervals.
// - CKE high, termination off during calibration.
// - Read/write waits tRCD minus AL after ACTIVATE.
// - Times round up to whole cycles.
// - Same-kind column commands spaced by tCCD.
// - Same-bank activates spaced by tRC.
// - Activates spaced tRRD, four per tFAW.
// - A2 selects upper nibble for chop four.
module dcm_ctrl #(
  parameter int unsigned NBANK = 8
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Link
  dcm_link_if.ctrl         lnk
);
  import dcm_pkg::*;

  logic [15:0] bank_rc_q [NBANK];
  logic [15:0] bank_rcd_q [NBANK];
  logic [NBANK-1:0] open_q;
  logic [15:0] rp_q, mrd_q, mod_q, mprr_q, rrd_q, ccd_rd_q, ccd_wr_q, zq_q;
  logic [15:0] faw_q [4];
  logic [3:0]  al_q;
  logic        pat_q;
  logic        busy_q;
  dcm_cmd_t    pend_cmd_q;
  logic [2:0]  pend_ba_q;
  logic [13:0] pend_addr_q;
  logic [16:0] addr_reg_q;
  logic [7:0]  cap_q;
  logic [7:0]  dq_s1_q, dq_s2_q;
  logic        ok;
  logic        issue;
  logic        acc;

  // Decides whether the pending command respects every limit.
  always_comb begin
    ok = 1'b0;
    case (pend_cmd_q)
      DCM_ACT:  ok = (rp_q == 0) && (mrd_q == 0) && (mod_q == 0) && (rrd_q == 0)
                     && (bank_rc_q[pend_ba_q] == 0) && !open_q[pend_ba_q]
                     && (faw_q[3] == 0) && (zq_q == 0);
      // Pattern reads run with every bank precharged, so they need no open row.
      DCM_RD:   ok = (open_q[pend_ba_q] || pat_q) && (ccd_rd_q == 0) && (zq_q == 0)
                     && (mrd_q == 0) && (mod_q == 0)
                     && ((bank_rcd_q[pend_ba_q] <= 16'(al_q)) || pat_q);
      DCM_WR:   ok = open_q[pend_ba_q] && !pat_q && (ccd_wr_q == 0) && (zq_q == 0)
                     && (bank_rcd_q[pend_ba_q] <= 16'(al_q)) && (mod_q == 0)
                     && (mrd_q == 0);
      DCM_PREA: ok = (zq_q == 0) && (mrd_q == 0);
      DCM_MRS:  ok = (open_q == '0) && (rp_q == 0) && (mrd_q == 0) && (zq_q == 0)
                     && (ccd_rd_q == 0) && (mprr_q == 0);
      DCM_ZQCL, DCM_ZQCS: ok = (open_q == '0) && (rp_q == 0) && (mrd_q == 0);
      default:  ok = 1'b1;
    endcase
  end

  assign issue = busy_q && ok;
  assign acc   = psel && penable;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  // Software command entry; calibration reads force their address bits.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_q      <= 1'b0;
      pend_cmd_q  <= DCM_NOP;
      pend_ba_q   <= 3'h0;
      pend_addr_q <= 14'h0000;
      addr_reg_q  <= 17'h00000;
    end else if (clk_en) begin
      if (issue) begin
        busy_q <= 1'b0;
      end
      if (acc && pwrite && paddr == REG_ADDR) begin
        addr_reg_q <= pwdata[16:0];
      end
      if (acc && pwrite && paddr == REG_CTRL && !busy_q) begin
        busy_q      <= 1'b1;
        pend_cmd_q  <= dcm_cmd_t'(pwdata[3:0]);
        pend_ba_q   <= addr_reg_q[16:14];
        pend_addr_q <= addr_reg_q[13:0];
        if (pat_q && dcm_cmd_t'(pwdata[3:0]) == DCM_RD) begin
          pend_addr_q <= 14'h1000 | (addr_reg_q[13:0] & 14'h0004);
        end
      end
    end
  end

  // Command drive; outputs come from flip-flops.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lnk.cmd  <= DCM_NOP;
      lnk.ba   <= 3'h0;
      lnk.addr <= 14'h0000;
      lnk.cke  <= 1'b1;
      lnk.odt  <= 1'b0;
    end else if (clk_en) begin
      lnk.cmd  <= issue ? pend_cmd_q : DCM_NOP;
      lnk.ba   <= pend_ba_q;
      lnk.addr <= pend_addr_q;
      lnk.cke  <= 1'b1;
      lnk.odt  <= 1'b0;
    end
  end

  // Global down-counters and mode tracking.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      {rp_q, mrd_q, mod_q, mprr_q, rrd_q, ccd_rd_q, ccd_wr_q, zq_q} <= '0;
      al_q  <= AL_RST;
      pat_q <= 1'b0;
      open_q <= '0;
      for (int i = 0; i < 4; i++) begin
        faw_q[i] <= 16'h0000;
      end
    end else if (clk_en) begin
      rp_q <= (rp_q != 0) ? rp_q - 16'h1 : 16'h0;
      mrd_q <= (mrd_q != 0) ? mrd_q - 16'h1 : 16'h0;
      mod_q <= (mod_q != 0) ? mod_q - 16'h1 : 16'h0;
      mprr_q <= (mprr_q != 0) ? mprr_q - 16'h1 : 16'h0;
      rrd_q <= (rrd_q != 0) ? rrd_q - 16'h1 : 16'h0;
      ccd_rd_q <= (ccd_rd_q != 0) ? ccd_rd_q - 16'h1 : 16'h0;
      ccd_wr_q <= (ccd_wr_q != 0) ? ccd_wr_q - 16'h1 : 16'h0;
      zq_q <= (zq_q != 0) ? zq_q - 16'h1 : 16'h0;
      for (int i = 0; i < 4; i++) begin
        faw_q[i] <= (faw_q[i] != 0) ? faw_q[i] - 16'h1 : 16'h0;
      end
      if (issue) begin
        case (pend_cmd_q)
          DCM_ACT: begin
            rrd_q <= RRD_CYC;
            faw_q[0] <= FAW_CYC;
            for (int i = 1; i < 4; i++) begin
              faw_q[i] <= (faw_q[i-1] != 0) ? faw_q[i-1] - 16'h1 : 16'h0;
            end
            open_q[pend_ba_q] <= 1'b1;
          end
          DCM_RD: begin
            ccd_rd_q <= CCD_CYC;
            mprr_q   <= pat_q ? MPRR_CYC : 16'h0;
          end
          DCM_WR: ccd_wr_q <= CCD_CYC;
          DCM_PREA: begin
            open_q <= '0;
            rp_q   <= RP_CYC;
          end
          DCM_MRS: begin
            mrd_q <= MRD_CYC;
            mod_q <= MOD_CYC;
            if (pend_ba_q == MR_THREE_SEL) begin
              pat_q <= pend_addr_q[PAT_BIT];
            end
            if (pend_ba_q == 3'h1) begin
              al_q <= pend_addr_q[6:3];
            end
          end
          DCM_ZQCL: zq_q <= ZQOPER_CYC;
          DCM_ZQCS: zq_q <= ZQCS_CYC;
          default: ;
        endcase
      end
    end
  end

  // Per-bank activate spacing, generated per bank.
  for (genvar b = 0; b < NBANK; b++) begin : g_bank
    always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
        bank_rc_q[b]  <= 16'h0000;
        bank_rcd_q[b] <= 16'h0000;
      end else if (clk_en) begin
        if (issue && pend_cmd_q == DCM_ACT && pend_ba_q == 3'(b)) begin
          bank_rc_q[b]  <= RC_CYC;
          bank_rcd_q[b] <= RCD_CYC;
        end else begin
          bank_rc_q[b]  <= (bank_rc_q[b] != 0) ? bank_rc_q[b] - 16'h1 : 16'h0;
          bank_rcd_q[b] <= (bank_rcd_q[b] != 0) ? bank_rcd_q[b] - 16'h1 : 16'h0;
        end
      end
    end
  end

  // Read data capture for software calibration sweeps.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dq_s1_q <= 8'h00;
      dq_s2_q <= 8'h00;
      cap_q   <= 8'h00;
    end else if (clk_en) begin
      dq_s1_q <= lnk.dq;
      dq_s2_q <= dq_s1_q;
      cap_q   <= {cap_q[6:0], dq_s2_q[0]};
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata <= 32'h00000000;
    end else if (clk_en) begin
      prdata <= 32'h00000000;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          REG_CTRL:   prdata <= {28'h0000000, pend_cmd_q};
          REG_STATUS: prdata <= {27'h0000000, lnk.zq_path_on, zq_q != 0, open_q != '0,
                                 pat_q, busy_q};
          REG_ADDR:   prdata <= {15'h0000, addr_reg_q};
          REG_RDATA:  prdata <= {24'h000000, cap_q};
          default:    prdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule : dcm_ctrl

//--- dv/dcm_link_monitor.sv
// Purpose: Checker for the command link between the two ends.
// Assumes: AL 0 and CL 5 stay programmed for the whole run.
// Notes:   Gap counters saturate, so old history never wraps into a false hit.
`timescale 1ns/1ns
module dcm_link_monitor (
  // Clock and reset
  input wire logic              ref_clk,
  input wire logic              sys_rst,
  // Link
  input wire dcm_pkg::dcm_cmd_t cmd,
  input wire logic [2:0]        ba,
  input wire logic [13:0]       addr,
  input wire logic              cke,
  input wire logic              odt,
  input wire logic [7:0]        dq_oe,
  input wire logic [7:0]        dq,
  input wire logic              zq_path_on
);
  import dcm_pkg::*;
  logic [15:0] mrs_q;
  logic [15:0] rd_q;
  logic [15:0] zq_q;
  logic        pat_q;
  logic        open_q;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mrs_q <= 16'hffff;
    end else if (cmd == DCM_MRS) begin
      mrs_q <= 16'h0001;
    end else if (mrs_q != 16'hffff) begin
      mrs_q <= mrs_q + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_q <= 16'hffff;
    end else if (cmd == DCM_RD) begin
      rd_q <= 16'h0001;
    end else if (rd_q != 16'hffff) begin
      rd_q <= rd_q + 16'h0001;
    end
  end

  // Loaded one short, so the count reaches zero exactly when the quiet time ends.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      zq_q <= 16'h0000;
    end else if (cmd == DCM_ZQCL) begin
      zq_q <= ZQOPER_CYC - 16'h0001;
    end else if (cmd == DCM_ZQCS) begin
      zq_q <= ZQCS_CYC - 16'h0001;
    end else if (zq_q != 16'h0000) begin
      zq_q <= zq_q - 16'h0001;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pat_q  <= 1'b0;
      open_q <= 1'b0;
    end else begin
      if (cmd == DCM_MRS && ba == MR_THREE_SEL) begin
        pat_q <= addr[PAT_BIT];
      end
      if (cmd == DCM_ACT) begin
        open_q <= 1'b1;
      end else if (cmd == DCM_PREA) begin
        open_q <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence s_pattern;
    ##6 (dq_oe == 8'hff && dq == 8'h00) ##1 dq == 8'hff ##1 dq == 8'h00 ##1 dq == 8'hff;
  endsequence

  a_mrd_gap_kept: assert property (cmd != DCM_NOP |-> mrs_q >= MRD_CYC)
    else $error("command too soon after a mode set");
  a_mod_before_act: assert property (cmd == DCM_ACT |-> mrs_q >= MOD_CYC)
    else $error("activate before the mode update time");
  a_zq_quiet_kept: assert property ((zq_q != 16'h0 && cmd != DCM_NOP) |-> cmd inside {DCM_ZQCL, DCM_ZQCS})
    else $error("command inside the calibration quiet time");
  a_zq_pins_held: assert property (zq_q != 16'h0 |-> cke && !odt && dq_oe == 8'h00)
    else $error("pins disturbed during calibration");
  a_pat_no_write: assert property (cmd == DCM_WR |-> !pat_q)
    else $error("write while pattern mode is on");
  a_pat_read_addr: assert property ((cmd == DCM_RD && pat_q) |-> addr[12] && addr[1:0] == 2'h0)
    else $error("bad address on a pattern read");
  a_pat_burst_out: assert property ((cmd == DCM_RD && pat_q) |-> s_pattern)
    else $error("pattern burst wrong or late");
  a_read_gap_kept: assert property ((cmd == DCM_RD && open_q) |-> rd_q >= CCD_CYC)
    else $error("reads closer than the column gap");
  a_col_needs_row: assert property ((cmd inside {DCM_RD, DCM_WR} && !pat_q) |-> open_q)
    else $error("column command with no open row");
  a_mrs_banks_idle: assert property (cmd == DCM_MRS |-> !open_q)
    else $error("mode set with a bank open");
  a_zq_path_off: assert property (cmd == DCM_ZQCS |-> ##[1:2] zq_path_on ##[60:70] !zq_path_on)
    else $error("calibration path not switched off");

  c_pat_read: cover property (cmd == DCM_RD && pat_q);
  c_zq_long: cover property (cmd == DCM_ZQCL);
  c_mrs_three: cover property (cmd == DCM_MRS && ba == MR_THREE_SEL);
endmodule : dcm_link_monitor

//--- dv/dcm_tb_top.sv
// Purpose: Self-checking bench driving the controller over APB into the DRAM end.
// Assumes: Software waits for busy to clear before the next command.
// Notes:   Every expected link command is queued by the driver and popped by a watcher.
`timescale 1ns/1ns
module ddr3_cal_mrs_zq_activate_rules_tb_top;
  import dcm_pkg::*;
  logic        ref_clk;
  logic        sys_rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rd_v;
  logic        pready;
  logic        pslverr;
  logic [13:0] mode_reg_q [4];
  logic        pat_mode_q;
  logic [13:0] ma;
  logic [21:0] ev;
  logic [21:0] exp_q [$];
  int          failures;
  int          total_checks;

  dcm_link_if lnk ();
  dcm_ctrl i_dcm_ctrl (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .lnk(lnk));
  dcm_dram i_dcm_dram (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(1'b1), .lnk(lnk),
    .mode_reg_q(mode_reg_q), .pat_mode_q(pat_mode_q));
  dcm_link_monitor i_dcm_link_monitor (.ref_clk(ref_clk), .sys_rst(sys_rst), .cmd(lnk.cmd),
    .ba(lnk.ba), .addr(lnk.addr), .cke(lnk.cke), .odt(lnk.odt), .dq_oe(lnk.dq_oe),
    .dq(lnk.dq), .zq_path_on(lnk.zq_path_on));

  initial ref_clk = 1'b0;
  always #20 ref_clk = ~ref_clk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      failures++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rd_v = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // A full flag of 0 means only the command code is compared.
  task automatic issue(input dcm_cmd_t c, input logic [2:0] b, input logic [13:0] a,
                       input logic [13:0] ea, input logic full);
    exp_q.push_back({full, c, b, ea});
    apb(1'b1, REG_ADDR, {15'h0, b, a});
    apb(1'b1, REG_CTRL, {28'h0, c});
    for (int n = 0; n < 400; n++) begin
      apb(1'b0, REG_STATUS, 32'h0);
      if (rd_v[0] === 1'b0) break;
    end
    repeat (2) @(posedge ref_clk);
  endtask : issue

  always @(posedge ref_clk) begin
    if (sys_rst === 1'b0 && lnk.cmd !== DCM_NOP) begin
      chk({31'h0, exp_q.size() != 0}, 32'h1);
      if (exp_q.size() != 0) begin
        ev = exp_q.pop_front();
        chk({28'h0, lnk.cmd}, {28'h0, ev[20:17]});
        if (ev[21]) begin
          chk({15'h0, lnk.ba, lnk.addr}, {15'h0, ev[16:0]});
        end
      end
    end
  end

  initial begin
    #(40 * 30000);
    failures++;
    tally_and_finish();
  end

  initial begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    failures = 0;
    total_checks = 0;
    ma = 14'($urandom(32'ha9ab1ea5));
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    // Latency fields are pinned so the pattern burst lands where the checker expects.
    for (int i = 0; i < 4; i++) begin
      ma = 14'($urandom());
      if (i == 0) ma[7:4] = 4'h5;
      if (i == 1) ma[6:3] = 4'h0;
      if (i == 3) ma[2] = 1'b0;
      issue(DCM_MRS, 3'(i), ma, ma, 1'b1);
      chk({18'h0, mode_reg_q[i]}, {18'h0, ma});
    end
    $display("test mode_set done");
    for (int b = 0; b < 5; b++) begin
      ma = 14'($urandom());
      issue(DCM_ACT, 3'(b), ma, ma, 1'b1);
    end
    apb(1'b0, REG_STATUS, 32'h0);
    chk({31'h0, rd_v[2]}, 32'h1);
    for (int k = 0; k < 2; k++) begin
      ma = 14'($urandom());
      issue(DCM_RD, 3'h1, ma, ma, 1'b1);
    end
    issue(DCM_WR, 3'h2, ma, ma, 1'b1);
    issue(DCM_PREA, 3'h0, 14'h0, 14'h0, 1'b0);
    apb(1'b0, REG_STATUS, 32'h0);
    chk({31'h0, rd_v[2]}, 32'h0);
    $display("test activate done");
    issue(DCM_MRS, MR_THREE_SEL, 14'h0004, 14'h0004, 1'b1);
    // Pattern mode only takes hold once the mode update time has run out.
    repeat (MOD_CYC) @(posedge ref_clk);
    chk({31'h0, pat_mode_q}, 32'h1);
    apb(1'b0, REG_STATUS, 32'h0);
    chk({31'h0, rd_v[1]}, 32'h1);
    for (int k = 0; k < 3; k++) begin
      ma = 14'($urandom());
      ma[2] = 1'b0;
      issue(DCM_RD, 3'h0, ma, {1'b0, 1'b1, 9'h000, ma[2], 2'h0}, 1'b1);
      repeat (12) @(posedge ref_clk);
    end
    issue(DCM_MRS, MR_THREE_SEL, 14'h0003, 14'h0003, 1'b1);
    repeat (MOD_CYC) @(posedge ref_clk);
    chk({31'h0, pat_mode_q}, 32'h0);
    $display("test calibration done");
    issue(DCM_ZQCL, 3'h0, 14'h0, 14'h0, 1'b0);
    apb(1'b0, REG_STATUS, 32'h0);
    chk({31'h0, rd_v[4]}, 32'h1);
    issue(DCM_ACT, 3'h2, ma, ma, 1'b1);
    issue(DCM_PREA, 3'h0, 14'h0, 14'h0, 1'b0);
    issue(DCM_ZQCS, 3'h0, 14'h0, 14'h0, 1'b0);
    issue(DCM_ACT, 3'h3, ma, ma, 1'b1);
    issue(DCM_PREA, 3'h0, 14'h0, 14'h0, 1'b0);
    $display("test impedance done");
    apb(1'b0, 8'h3c, 32'h0);
    chk(rd_v, 32'h0);
    chk(32'(exp_q.size()), 32'h0);
    $display("test unmapped done");
    tally_and_finish();
  end
endmodule : ddr3_cal_mrs_zq_activate_rules_tb_top
